// File: rtl/snv_serial_nvram.sv
// serial command port of a 16 x 16 nonvolatile static ram
//
// How it works
// - start bit, four address bits, three-bit opcode
// - opcode 100 sets, 000 clears write latch
// - 001 saves ram to nv, 101 restores
// - 011 writes word, 11x reads word
// - input bits sampled on serial clock rise
// - output driven only while shifting read data
// - write takes exactly sixteen data bits
// - read ignores eighth bit, sends sixteen bits
// - first bit after eighth fall, rest rises
// - early deselect discards instruction, clears shifter
// - static interface, clock may pause anytime
// - power-up clears the write latch
// - writes and saves need prior enable command
// - latch holds until disable or save done
// - reads work regardless of write latch
// - store and recall pins trigger transfers
// - sixteen words of sixteen bits, addressed
// - recalled data usable within access time
// - recall needed before save or write
// - save needs both latches and a request
// - save inhibits all, then clears latch
// - recall pin active low starts restore
`timescale 1ns/1ns
`include "snv_regs.svh"
module snv_serial_nvram import snv_pkg::*; #(
   parameter int WORD_W = `SNV_WORD_W,
   parameter int ADDR_W = `SNV_ADDR_W,
   parameter int STORE_TIME_CYCLES = `SNV_STORE_TIME_CYC
)(
   // clock and reset
   input wire logic MCLK_IN,
   input wire logic RSTN_IN,
   // serial link from the host
   input wire logic SERIAL_CLOCK_PIN_IN,
   input wire logic SERIAL_IN_PIN_IN,
   input wire logic CHIP_ENABLE_IN,
   // serial data output, three-state
   output logic SERIAL_OUT_OUT,
   output logic SERIAL_OUT_OE_OUT,
   // hardware transfer pins, active low
   input wire logic STORE_N_IN,
   input wire logic RECALL_N_IN,
   // status
   output logic WRITE_ENABLE_OUT,
   output logic PREV_RECALL_OUT,
   output logic STORE_BUSY_OUT
);

   // ------------------------------------------------------------
   // local sizes
   // ------------------------------------------------------------
   localparam int CW = $clog2(WORD_W) + 1;
   localparam int TW = $clog2(STORE_TIME_CYCLES + 1);
   localparam int OPW = `SNV_OP_W;

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic clk_prev_reg;
   logic clk_rise;
   logic clk_fall;
   logic active;
   snv_state_t state_reg;
   snv_state_t state_next;
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic [WORD_W-1:0] sh_reg;
   logic [WORD_W-1:0] sh_next;
   logic [ADDR_W-1:0] addr_reg;
   logic [ADDR_W-1:0] addr_next;
   snv_op_t op_now;
   logic [ADDR_W-1:0] addr_now;
   logic [WORD_W-1:0] wdata_now;
   logic cmd_end;
   logic read_go;
   logic write_go;
   logic disable_go;
   logic enable_go;
   logic save_sw;
   logic restore_sw;
   logic hw_idle;
   logic save_go;
   logic restore_go;
   logic store_done;
   logic wel_reg;
   logic prl_reg;
   logic store_busy_reg;
   logic [TW-1:0] store_cnt_reg;
   logic rd_pend_reg;
   logic rd_en;
   logic mem_wr_en;
   logic [WORD_W-1:0] mem_rd_data;
   logic mem_rd_valid;
   logic buf_in_ready;
   logic buf_out_valid;
   logic [WORD_W-1:0] buf_out_data;
   logic load_word;
   logic shift_bit;
   logic end_read;
   logic [WORD_W-1:0] out_sh_reg;
   logic sd_out_reg;
   logic sd_oe_reg;

   // ------------------------------------------------------------
   // opcode decode
   // ------------------------------------------------------------
   // the eighth bit is never looked at for a read
   function automatic logic is_read(input snv_op_t op);
      is_read = (op[OPW-1:1] == `SNV_READ_CMD_HI);
   endfunction

   function automatic logic is_op(input snv_op_t op, input snv_op_t code);
      is_op = !is_read(op) && (op == code);
   endfunction

   // ------------------------------------------------------------
   // serial clock edges
   // ------------------------------------------------------------
   // the link clock is just sampled, so a paused clock stalls nothing
   always_ff @(posedge MCLK_IN) begin
      if (!RSTN_IN) begin
         clk_prev_reg <= 1'b0;
      end else begin
         clk_prev_reg <= SERIAL_CLOCK_PIN_IN;
      end
   end

   assign clk_rise = SERIAL_CLOCK_PIN_IN && !clk_prev_reg;
   assign clk_fall = !SERIAL_CLOCK_PIN_IN && clk_prev_reg;

   // deselect or a running save holds the whole serial side in idle and clears it
   assign active = CHIP_ENABLE_IN && !store_busy_reg;

   // ------------------------------------------------------------
   // instruction fields
   // ------------------------------------------------------------
   assign op_now = {sh_reg[OPW-2:0], SERIAL_IN_PIN_IN};
   assign addr_now = sh_reg[OPW+ADDR_W-2:OPW-1];
   assign wdata_now = {sh_reg[WORD_W-2:0], SERIAL_IN_PIN_IN};

   // eighth rising edge completes the instruction
   assign cmd_end = active && clk_rise && (state_reg == ST_CMD) &&
      (cnt_reg == CW'(`SNV_CMD_BITS - 1));

   assign read_go = cmd_end && is_read(op_now);
   assign disable_go = cmd_end && is_op(op_now, `SNV_DISABLE_WRITES_CMD);
   assign enable_go = cmd_end && is_op(op_now, `SNV_ENABLE_WRITES_CMD);
   assign save_sw = cmd_end && is_op(op_now, `SNV_SAVE_TO_NV_CMD);
   assign restore_sw = cmd_end && is_op(op_now, `SNV_RESTORE_FROM_NV_CMD);

   // sixteenth data bit of a write
   assign write_go = active && clk_rise && (state_reg == ST_WDATA) &&
      (cnt_reg == CW'(WORD_W - 1));

   // ------------------------------------------------------------
   // read data output pulses
   // ------------------------------------------------------------
   assign load_word = active && clk_fall && (state_reg == ST_RDATA) &&
      (cnt_reg == '0) && buf_out_valid;
   assign shift_bit = active && clk_rise && (state_reg == ST_RDATA) &&
      (cnt_reg != '0) && (cnt_reg != CW'(WORD_W));
   assign end_read = active && clk_rise && (state_reg == ST_RDATA) &&
      (cnt_reg == CW'(WORD_W));

   // ------------------------------------------------------------
   // serial sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      sh_next = sh_reg;
      addr_next = addr_reg;
      if (!active) begin
         // partial instruction is dropped, shifter cleared
         state_next = ST_IDLE;
         cnt_next = '0;
         sh_next = '0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               // leading zeros before the start bit are ignored
               if (clk_rise && SERIAL_IN_PIN_IN) begin
                  state_next = ST_CMD;
                  cnt_next = CW'(1);
               end
            end
            ST_CMD: begin
               if (clk_rise) begin
                  sh_next = {sh_reg[WORD_W-2:0], SERIAL_IN_PIN_IN};
                  cnt_next = cnt_reg + 1'b1;
                  if (cmd_end) begin
                     addr_next = addr_now;
                     sh_next = '0;
                     cnt_next = '0;
                     if (read_go) begin
                        state_next = ST_RDATA;
                     end else if (op_now == `SNV_WRITE_CMD) begin
                        state_next = ST_WDATA;
                     end else begin
                        state_next = ST_DONE;
                     end
                  end
               end
            end
            ST_WDATA: begin
               if (clk_rise) begin
                  sh_next = wdata_now;
                  cnt_next = cnt_reg + 1'b1;
                  if (write_go) begin
                     state_next = ST_DONE;
                  end
               end
            end
            ST_RDATA: begin
               if (load_word || shift_bit) begin
                  cnt_next = cnt_reg + 1'b1;
               end else if (end_read) begin
                  state_next = ST_DONE;
               end
            end
            ST_DONE: begin
               // extra clocks are ignored until deselect
               state_next = ST_DONE;
            end
            default: begin
               state_next = ST_IDLE;
               cnt_next = '0;
            end
         endcase
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RSTN_IN) begin
         state_reg <= ST_IDLE;
         cnt_reg <= '0;
         sh_reg <= '0;
         addr_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         sh_reg <= sh_next;
         addr_reg <= addr_next;
      end
   end

   // ------------------------------------------------------------
   // transfer requests
   // ------------------------------------------------------------
   // pins act only while no instruction is in flight
   assign hw_idle = (state_reg == ST_IDLE) && !store_busy_reg;

   // save has priority over a recall on the same cycle
   assign save_go = !store_busy_reg && wel_reg && prl_reg &&
      (save_sw || (hw_idle && !STORE_N_IN));
   assign restore_go = restore_sw ||
      (hw_idle && !RECALL_N_IN && !save_go);

   assign store_done = store_busy_reg && (store_cnt_reg == '0);

   // ram writes need both latches, reads need neither
   assign mem_wr_en = write_go && wel_reg && prl_reg;

   // ------------------------------------------------------------
   // write enable latch
   // ------------------------------------------------------------
   always_ff @(posedge MCLK_IN) begin
      if (!RSTN_IN) begin
         wel_reg <= 1'b0;
      end else if (enable_go) begin
         wel_reg <= 1'b1;
      end else if (disable_go || store_done) begin
         wel_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // previous recall latch
   // ------------------------------------------------------------
   always_ff @(posedge MCLK_IN) begin
      if (!RSTN_IN) begin
         prl_reg <= 1'b0;
      end else if (restore_go) begin
         prl_reg <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // save timer
   // ------------------------------------------------------------
   // the array copy is instant; the busy window models programming
   always_ff @(posedge MCLK_IN) begin
      if (!RSTN_IN) begin
         store_busy_reg <= 1'b0;
         store_cnt_reg <= '0;
      end else if (save_go) begin
         store_busy_reg <= 1'b1;
         store_cnt_reg <= TW'(STORE_TIME_CYCLES - 1);
      end else if (store_done) begin
         store_busy_reg <= 1'b0;
      end else if (store_busy_reg) begin
         store_cnt_reg <= store_cnt_reg - 1'b1;
      end
   end

   // ------------------------------------------------------------
   // read fetch, stalled by a full buffer
   // ------------------------------------------------------------
   assign rd_en = rd_pend_reg && buf_in_ready;

   always_ff @(posedge MCLK_IN) begin
      if (!RSTN_IN || !active) begin
         rd_pend_reg <= 1'b0;
      end else if (read_go) begin
         rd_pend_reg <= 1'b1;
      end else if (rd_en) begin
         rd_pend_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // memory and buffer
   // ------------------------------------------------------------
   snv_mem #(
      .WIDTH(WORD_W),
      .AW(ADDR_W)
   ) snv_mem_i (
      .clk_in(MCLK_IN),
      .rstn_in(RSTN_IN),
      .wr_en_in(mem_wr_en),
      .wr_addr_in(addr_reg),
      .wr_data_in(wdata_now),
      .rd_en_in(rd_en),
      .rd_addr_in(addr_reg),
      .rd_data_out(mem_rd_data),
      .rd_valid_out(mem_rd_valid),
      .save_all_in(save_go),
      .restore_all_in(restore_go)
   );

   snv_buf #(
      .WIDTH(WORD_W),
      .DEPTH(2)
   ) snv_buf_i (
      .clk_in(MCLK_IN),
      .rstn_in(RSTN_IN),
      .flush_in(!active),
      .in_valid_in(mem_rd_valid),
      .in_ready_out(buf_in_ready),
      .in_data_in(mem_rd_data),
      .out_valid_out(buf_out_valid),
      .out_ready_in(load_word),
      .out_data_out(buf_out_data)
   );

   // ------------------------------------------------------------
   // serial output shifter
   // ------------------------------------------------------------
   // most significant bit leaves first, matching the write order
   always_ff @(posedge MCLK_IN) begin
      if (!RSTN_IN) begin
         out_sh_reg <= '0;
         sd_out_reg <= 1'b0;
      end else if (load_word) begin
         sd_out_reg <= buf_out_data[WORD_W-1];
         out_sh_reg <= {buf_out_data[WORD_W-2:0], 1'b0};
      end else if (shift_bit) begin
         sd_out_reg <= out_sh_reg[WORD_W-1];
         out_sh_reg <= {out_sh_reg[WORD_W-2:0], 1'b0};
      end
   end

   // high impedance everywhere but the sixteen data bits
   always_ff @(posedge MCLK_IN) begin
      if (!RSTN_IN || !active) begin
         sd_oe_reg <= 1'b0;
      end else if (load_word) begin
         sd_oe_reg <= 1'b1;
      end else if (end_read) begin
         sd_oe_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign SERIAL_OUT_OUT = sd_out_reg;
   assign SERIAL_OUT_OE_OUT = sd_oe_reg;
   assign WRITE_ENABLE_OUT = wel_reg;
   assign PREV_RECALL_OUT = prl_reg;
   assign STORE_BUSY_OUT = store_busy_reg;

endmodule

// File: rtl/snv_regs.svh
// constants of the serial nonvolatile ram command port
`ifndef SNV_REGS_SVH
`define SNV_REGS_SVH

// ---------------------------------------------------------------
// array shape
// ---------------------------------------------------------------
`define SNV_WORD_W 16
`define SNV_ADDR_W 4
`define SNV_OP_W 3
`define SNV_CMD_BITS 8

// ---------------------------------------------------------------
// operation codes, low three bits of the instruction
// ---------------------------------------------------------------
`define SNV_DISABLE_WRITES_CMD 3'h0
`define SNV_SAVE_TO_NV_CMD 3'h1
`define SNV_WRITE_CMD 3'h3
`define SNV_ENABLE_WRITES_CMD 3'h4
`define SNV_RESTORE_FROM_NV_CMD 3'h5
`define SNV_READ_CMD_HI 2'h3

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SNV_CLK_PERIOD_NS 100
`define SNV_STORE_TIME_MS 10
`define SNV_STORE_TIME_CYC (`SNV_STORE_TIME_MS * 1000000 / `SNV_CLK_PERIOD_NS)
`define SNV_RECALL_ACCESS_TIME_NS 1500
`define SNV_RECALL_ACCESS_CYC (`SNV_RECALL_ACCESS_TIME_NS / `SNV_CLK_PERIOD_NS)

`endif

// File: rtl/snv_pkg.sv
// types of the serial nonvolatile ram command port
package snv_pkg;

   // ------------------------------------------------------------
   // serial sequencer states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CMD,
      ST_WDATA,
      ST_RDATA,
      ST_DONE
   } snv_state_t;

   typedef logic [2:0] snv_op_t;

endpackage

// File: rtl/snv_mem.sv
// ram array with its bit-for-bit nonvolatile shadow
`timescale 1ns/1ns
module snv_mem #(
   parameter int WIDTH = 16,
   parameter int AW = 4
)(
   // clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // word write port
   input wire logic wr_en_in,
   input wire logic [AW-1:0] wr_addr_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   // word read port, data one cycle later
   input wire logic rd_en_in,
   input wire logic [AW-1:0] rd_addr_in,
   output logic [WIDTH-1:0] rd_data_out,
   output logic rd_valid_out,
   // whole-array transfers
   input wire logic save_all_in,
   input wire logic restore_all_in
);
   localparam int DEPTH = 2 ** AW;

   logic [WIDTH-1:0] ram_reg [DEPTH];
   logic [WIDTH-1:0] nv_reg [DEPTH];

   // parallel copy, so a recall lands in one cycle
   always_ff @(posedge clk_in) begin
      if (restore_all_in) begin
         ram_reg <= nv_reg;
      end else if (wr_en_in) begin
         ram_reg[wr_addr_in] <= wr_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (save_all_in) begin
         nv_reg <= ram_reg;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rd_en_in) begin
         rd_data_out <= ram_reg[rd_addr_in];
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         rd_valid_out <= 1'b0;
      end else begin
         rd_valid_out <= rd_en_in;
      end
   end

endmodule

// File: rtl/snv_buf.sv
// small elastic buffer with valid and ready on both sides
`timescale 1ns/1ns
module snv_buf #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 2
)(
   // clock, reset and flush
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic flush_in,
   // filling side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // draining side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] cnt_reg;
   logic push;
   logic pop;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign in_ready_out = (cnt_reg != (AW + 1)'(DEPTH));
   assign out_valid_out = (cnt_reg != '0);
   assign out_data_out = mem_reg[rd_ptr_reg];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;

   // flush drops stale words left by an aborted transfer
   always_ff @(posedge clk_in) begin
      if (!rstn_in || flush_in) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= bump(wr_ptr_reg);
         end
         if (pop) begin
            rd_ptr_reg <= bump(rd_ptr_reg);
         end
         cnt_reg <= cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_in;
      end
   end

endmodule

// File: testbench/snv_monitor.sv
// assertion checker bound to the serial nvram command port
`timescale 1ns/1ns
module snv_monitor #(
   parameter int STORE_TIME_CYCLES = 20
)(
   // clock and reset
   input wire logic MCLK_IN,
   input wire logic RSTN_IN,
   // serial link and pins
   input wire logic SERIAL_CLOCK_PIN_IN,
   input wire logic CHIP_ENABLE_IN,
   input wire logic SERIAL_OUT_OE_OUT,
   input wire logic STORE_N_IN,
   input wire logic RECALL_N_IN,
   // status
   input wire logic WRITE_ENABLE_OUT,
   input wire logic PREV_RECALL_OUT,
   input wire logic STORE_BUSY_OUT
);
   logic sck_reg;
   logic [4:0] rise_reg;
   int busy_reg;
   wire logic rise = SERIAL_CLOCK_PIN_IN & ~sck_reg;
   wire logic fall = ~SERIAL_CLOCK_PIN_IN & sck_reg;
   always_ff @(posedge MCLK_IN) begin
      if (!RSTN_IN) sck_reg <= 1'b0;
      else sck_reg <= SERIAL_CLOCK_PIN_IN;
   end
   // rises seen while the output drives
   always_ff @(posedge MCLK_IN) begin
      if (!RSTN_IN || !SERIAL_OUT_OE_OUT) rise_reg <= 5'h00;
      else if (rise) rise_reg <= rise_reg + 5'h01;
   end
   always_ff @(posedge MCLK_IN) begin
      if (!RSTN_IN || !STORE_BUSY_OUT) busy_reg <= 0;
      else busy_reg <= busy_reg + 1;
   end
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (!RSTN_IN);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   a_reset_clears: assert property ($rose(RSTN_IN) |->
      !WRITE_ENABLE_OUT && !PREV_RECALL_OUT && !STORE_BUSY_OUT)
      else $error("latches not clear after reset");
   a_oe_deselect: assert property (!CHIP_ENABLE_IN |=>
      !SERIAL_OUT_OE_OUT) else $error("output driven while deselected");
   a_oe_from_fall: assert property ($rose(SERIAL_OUT_OE_OUT) |->
      $past(fall)) else $error("output enabled without clock fall");
   a_oe_sixteen: assert property (SERIAL_OUT_OE_OUT && rise &&
      rise_reg == 5'h0f |=> !SERIAL_OUT_OE_OUT)
      else $error("output held past sixteen bits");
   a_store_gate: assert property ($rose(STORE_BUSY_OUT) |->
      $past(WRITE_ENABLE_OUT) && $past(PREV_RECALL_OUT))
      else $error("store began without both latches");
   a_store_length: assert property ($fell(STORE_BUSY_OUT) |->
      busy_reg >= STORE_TIME_CYCLES && busy_reg <= STORE_TIME_CYCLES + 1)
      else $error("store busy window has wrong length");
   a_store_clears: assert property ($fell(STORE_BUSY_OUT) |->
      ##[0:1] !WRITE_ENABLE_OUT) else $error("latch kept after store");
   a_busy_inhibit: assert property (STORE_BUSY_OUT &&
      $past(STORE_BUSY_OUT) |-> !SERIAL_OUT_OE_OUT &&
      $stable(PREV_RECALL_OUT)) else $error("activity during store");
   a_recall_pin: assert property (!RECALL_N_IN && STORE_N_IN &&
      !CHIP_ENABLE_IN && !$past(CHIP_ENABLE_IN) && !STORE_BUSY_OUT
      |=> PREV_RECALL_OUT) else $error("recall pin not taken");
   a_store_pin: assert property (!STORE_N_IN && WRITE_ENABLE_OUT &&
      PREV_RECALL_OUT && !CHIP_ENABLE_IN && !$past(CHIP_ENABLE_IN) &&
      !STORE_BUSY_OUT |=> STORE_BUSY_OUT) else $error("store pin not taken");
endmodule
bind snv_serial_nvram snv_monitor #(
   .STORE_TIME_CYCLES(STORE_TIME_CYCLES)
) snv_monitor_i (
   .MCLK_IN(MCLK_IN), .RSTN_IN(RSTN_IN),
   .SERIAL_CLOCK_PIN_IN(SERIAL_CLOCK_PIN_IN),
   .CHIP_ENABLE_IN(CHIP_ENABLE_IN), .SERIAL_OUT_OE_OUT(SERIAL_OUT_OE_OUT),
   .STORE_N_IN(STORE_N_IN), .RECALL_N_IN(RECALL_N_IN),
   .WRITE_ENABLE_OUT(WRITE_ENABLE_OUT), .PREV_RECALL_OUT(PREV_RECALL_OUT),
   .STORE_BUSY_OUT(STORE_BUSY_OUT)
);

// File: testbench/snv_host.sv
// host model driving select, serial clock, data and transfer pins
`timescale 1ns/1ns
module snv_host (
   // clock and returned data
   input wire logic clk_in,
   input wire logic sdo_in,
   // serial link
   output logic sck_out,
   output logic sdi_out,
   output logic ce_out,
   // hardware pins
   output logic store_n_out,
   output logic recall_n_out
);
   // serial level length in clocks, 400 ns minimum
   int half = 4;
   initial begin
      sck_out = 1'b0;
      sdi_out = 1'b0;
      ce_out = 1'b0;
      store_n_out = 1'b1;
      recall_n_out = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   // n below the frame length aborts the instruction
   task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd,
      input int n, output logic [15:0] rd);
      rd = 16'h0000;
      @(posedge clk_in);
      ce_out <= 1'b1;
      tick(2 * half);
      for (int i = 0; i < n; i++) begin
         if (i < 8) sdi_out <= cmd[7-i];
         else if (cmd[2:1] == 2'h3) sdi_out <= ~sdi_out;
         else sdi_out <= wd[23-i];
         tick(half);
         @(negedge clk_in);
         if (i >= 8) rd = {rd[14:0], sdo_in};
         @(posedge clk_in);
         sck_out <= 1'b1;
         tick(half);
         sck_out <= 1'b0;
      end
      tick(half);
      ce_out <= 1'b0;
      sdi_out <= ~sdi_out;
      tick(2 * half);
   endtask
   // st high pulses store, low pulses recall; both widths met
   task automatic pin(input logic st);
      @(posedge clk_in);
      if (st) store_n_out <= 1'b0;
      else recall_n_out <= 1'b0;
      tick(6);
      store_n_out <= 1'b1;
      recall_n_out <= 1'b1;
   endtask
endmodule

// File: testbench/test_serial_nvram_command_port.sv
// self-checking bench for the serial nvram command port
`timescale 1ns/1ns
`include "snv_regs.svh"
module test_serial_nvram_command_port import snv_pkg::*;;
   localparam int ST = 20;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic sck, sdi, ce, sdo, oe, st_n, rc_n, wel, prl, busy;
   logic [15:0] rd;
   int n_mismatch = 0;
   int n_tests = 0;
   always #50 mclk = ~mclk;
   snv_serial_nvram #(.STORE_TIME_CYCLES(ST)) snv_serial_nvram_i (
      .MCLK_IN(mclk), .RSTN_IN(rstn), .SERIAL_CLOCK_PIN_IN(sck),
      .SERIAL_IN_PIN_IN(sdi), .CHIP_ENABLE_IN(ce), .SERIAL_OUT_OUT(sdo),
      .SERIAL_OUT_OE_OUT(oe), .STORE_N_IN(st_n), .RECALL_N_IN(rc_n),
      .WRITE_ENABLE_OUT(wel), .PREV_RECALL_OUT(prl), .STORE_BUSY_OUT(busy));
   // a released output reads back inverted, so late enables show up
   snv_host snv_host_i (.clk_in(mclk), .sdo_in(oe ? sdo : ~sdo),
      .sck_out(sck), .sdi_out(sdi), .ce_out(ce), .store_n_out(st_n),
      .recall_n_out(rc_n));
   // ------------------------------------------------------------
   // compares and bus helpers
   // ------------------------------------------------------------
   task automatic chk1(input string what, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic chk16(input string what, input logic [15:0] e,
      input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", what, e, g);
      end
   endtask
   function automatic logic [15:0] pat(input logic [3:0] a);
      return 16'h5a3c ^ {4{a}};
   endfunction
   task automatic op(input logic [2:0] c);
      host_call({1'b1, 4'h0, c}, 16'h0000, 8);
   endtask
   task automatic host_call(input logic [7:0] c, input logic [15:0] d,
      input int n);
      snv_host_i.xfer(c, d, n, rd);
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      host_call({1'b1, a, `SNV_WRITE_CMD}, d, 24);
   endtask
   // odd addresses use the other don't-care eighth bit
   task automatic rdw(input logic [3:0] a, input logic [15:0] e);
      host_call({1'b1, a, `SNV_READ_CMD_HI, a[0]}, 16'h0000, 24);
      chk16("read word", e, rd);
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      chk1("write latch", 1'b0, wel);
      chk1("recall latch", 1'b0, prl);
      chk1("busy", 1'b0, busy);
      chk1("output enable", 1'b0, oe);
   endtask
   task automatic t_latch();
      op(`SNV_ENABLE_WRITES_CMD);
      chk1("write latch", 1'b1, wel);
      snv_host_i.pin(1'b1);
      chk1("busy", 1'b0, busy);
      op(`SNV_DISABLE_WRITES_CMD);
      chk1("write latch", 1'b0, wel);
   endtask
   task automatic t_abort();
      host_call({1'b1, 4'h0, `SNV_ENABLE_WRITES_CMD}, 16'h0000, 7);
      chk1("write latch", 1'b0, wel);
      op(`SNV_ENABLE_WRITES_CMD);
      chk1("write latch", 1'b1, wel);
      op(`SNV_DISABLE_WRITES_CMD);
   endtask
   task automatic t_words();
      snv_host_i.pin(1'b0);
      chk1("recall latch", 1'b1, prl);
      op(`SNV_ENABLE_WRITES_CMD);
      for (int a = 0; a < 16; a++) wr(a[3:0], pat(a[3:0]));
      chk1("write latch", 1'b1, wel);
      op(`SNV_DISABLE_WRITES_CMD);
      wr(4'h0, 16'h0000);
      for (int a = 0; a < 16; a++) rdw(a[3:0], pat(a[3:0]));
   endtask
   task automatic t_store();
      op(`SNV_ENABLE_WRITES_CMD);
      op(`SNV_SAVE_TO_NV_CMD);
      chk1("busy", 1'b1, busy);
      repeat (ST) @(posedge mclk);
      chk1("busy", 1'b0, busy);
      chk1("write latch", 1'b0, wel);
      op(`SNV_ENABLE_WRITES_CMD);
      wr(4'h3, 16'h0000);
      op(`SNV_RESTORE_FROM_NV_CMD);
      repeat (`SNV_RECALL_ACCESS_CYC) @(posedge mclk);
      rdw(4'h3, pat(4'h3));
   endtask
   task automatic t_pins();
      op(`SNV_ENABLE_WRITES_CMD);
      wr(4'h5, 16'hffff);
      snv_host_i.pin(1'b1);
      chk1("busy", 1'b1, busy);
      repeat (ST) @(posedge mclk);
      chk1("write latch", 1'b0, wel);
      op(`SNV_ENABLE_WRITES_CMD);
      wr(4'h5, 16'h1234);
      snv_host_i.pin(1'b0);
      rdw(4'h5, 16'hffff);
   endtask
   // slow serial clock: state must survive long pauses
   task automatic t_pause();
      snv_host_i.half = 20;
      rdw(4'h5, 16'hffff);
      snv_host_i.half = 4;
   endtask
   task automatic summarize();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // limit well above the roughly 12000 cycles of traffic
   initial begin
      #3000000;
      n_mismatch++;
      summarize();
   end
   initial begin
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      repeat (2) @(posedge mclk);
      t_reset();
      t_latch();
      t_abort();
      t_words();
      t_store();
      t_pins();
      t_pause();
      summarize();
   end
endmodule
